// *** hdl/dbs_sram_port.sv ***
/*
 * device side of a two-word burst ddr sram: command capture, posted writes
 * with read bypass, ddr read launch, echo clocks, dll lock and impedance timer.
 * assumes link_k is the host input clock with its complement taken as the
 * falling edge, output clocks phase-aligned to it, and clk_sys free running.
 */
// Operation
// - single-clock mode times inputs and outputs from the input clock pair only
// - otherwise write data on both input edges, read data on both output edges
// - a write is parked in holding registers rather than written at once
// - next write commits the parked write to the array
// - reads of recently written addresses return holding register data
// - output impedance is updated every 1024 cycles from power-up
// - two free-running echo clocks follow the output clock pair
// - in single-clock mode the true echo follows the complement input clock
// - dll locks 1024 stable input clock cycles after start or disturbance
// - input clock slowed or stopped for 30 ns resets the dll
// - dll disabled gives one-cycle read latency
// - write: word one at true rise of t+1, word two at complement rise
// - read: word one at complement rise of t+1, word two at true rise t+2
// - device leaves reset deselected with data outputs off
// - active-low lane selects enable writing bits 8:0 and 17:9 per half
// - all lane selects high writes nothing for that half
// - second burst address flips the lsb of the first
// - deselected reads finish, then outputs turn off after the next true edge
`timescale 1ns/100ps
module dbs_sram_port #(
    parameter int ADDR_W = dbs_pkg::ADDR_W,
    parameter int WORD_W = dbs_pkg::WORD_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic link_k,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic load_strobe_n,
    input wire logic read_sel,
    input wire logic [WORD_W-1:0] d_in,
    input wire logic [dbs_pkg::LANES-1:0] byte_lane_write_n,
    input wire logic out_clk_true,
    input wire logic out_clk_comp,
    input wire logic dll_disable_n,
    output logic [WORD_W-1:0] q_out,
    output logic q_oe,
    output logic echo_clock_true,
    output logic echo_clock_comp,
    output logic dll_locked,
    output logic imp_update
);
    localparam int LN = dbs_pkg::LANES;
    localparam int LW = WORD_W / LN;
    localparam int BW = dbs_pkg::BURST * WORD_W;

    if (ADDR_W < 2 || WORD_W != LN * LW || LW != dbs_pkg::LANE_W) begin : g_chk
        $error("dbs_sram_port: unsupported address or word width");
    end

    // second burst address
    function automatic logic [ADDR_W-1:0] burst_next(input logic [ADDR_W-1:0] a);
        burst_next = {a[ADDR_W-1:1], ~a[0]};
    endfunction

    // overlay new lanes on old data where the lane select is low
    function automatic logic [WORD_W-1:0] lane_merge(
        input logic [WORD_W-1:0] nd,
        input logic [LN-1:0] lane_n,
        input logic [WORD_W-1:0] od
    );
        lane_merge = od;
        for (int l = 0; l < LN; l++) begin
            if (!lane_n[l])
                lane_merge[l*LW +: LW] = nd[l*LW +: LW];
        end
    endfunction

    // newest value of address x given a two-word burst stored at base a
    function automatic logic [WORD_W-1:0] burst_pick(
        input logic [ADDR_W-1:0] x,
        input logic hit,
        input logic [ADDR_W-1:0] a,
        input logic [BW-1:0] data,
        input logic [2*LN-1:0] lane_n,
        input logic [WORD_W-1:0] od
    );
        burst_pick = od;
        if (hit && a == x)
            burst_pick = lane_merge(data[WORD_W-1:0], lane_n[LN-1:0], od);
        else if (hit && burst_next(a) == x)
            burst_pick = lane_merge(data[BW-1:WORD_W], lane_n[2*LN-1:LN], od);
    endfunction

    dbs_core_if #(.AW(ADDR_W), .W(WORD_W), .LN(LN)) core_bus ();

    dbs_core #(.AW(ADDR_W), .W(WORD_W), .LN(LN)) u_core (
        .clk(link_k),
        .bus(core_bus)
    );

    // ---------------- link domain: synchronisers and strap ----------------
    logic [dbs_pkg::SYNC_W-1:0] rst_k_sync_reg;
    logic [dbs_pkg::SYNC_W-1:0] ct_sync_reg;
    logic [dbs_pkg::SYNC_W-1:0] cc_sync_reg;
    logic [dbs_pkg::SYNC_W-1:0] dll_disable_n_sync_reg;
    logic [dbs_pkg::SYNC_W-1:0] stop_k_sync_reg;
    logic single_clk_reg;
    logic clk_stop_reg;

    always_ff @(posedge link_k) begin
        rst_k_sync_reg <= {rst_k_sync_reg[0], rst};
        ct_sync_reg <= {ct_sync_reg[0], out_clk_true};
        cc_sync_reg <= {cc_sync_reg[0], out_clk_comp};
        dll_disable_n_sync_reg <= {dll_disable_n_sync_reg[0], dll_disable_n};
        stop_k_sync_reg <= {stop_k_sync_reg[0], clk_stop_reg};
    end

    wire rst_k = rst_k_sync_reg[1];
    wire dll_on = dll_disable_n_sync_reg[1];
    wire stop_k = stop_k_sync_reg[1];

    // strap sampled while reset is held, frozen afterwards
    always_ff @(posedge link_k) begin
        if (rst_k)
            single_clk_reg <= ct_sync_reg[1] & cc_sync_reg[1];
    end

    // ---------------- link domain: command and write path ----------------
    logic cmd_valid_reg;
    logic cmd_read_reg;
    logic [ADDR_W-1:0] cmd_addr_reg;
    logic wpend_reg;
    logic [ADDR_W-1:0] waddr_reg;
    logic [WORD_W-1:0] wd0_reg;
    logic [LN-1:0] wm0_reg;
    logic [WORD_W-1:0] wd1_neg_reg;
    logic [LN-1:0] wm1_neg_reg;
    logic hold_valid_reg;
    logic [ADDR_W-1:0] hold_addr_reg;
    logic [BW-1:0] hold_data_reg;
    logic [2*LN-1:0] hold_lane_reg;

    wire wr_go = cmd_valid_reg & ~cmd_read_reg;
    wire rd_go = cmd_valid_reg & cmd_read_reg;
    wire [BW-1:0] wbuf_data = {wd1_neg_reg, wd0_reg};
    wire [2*LN-1:0] wbuf_lane = {wm1_neg_reg, wm0_reg};

    always_ff @(posedge link_k) begin
        if (rst_k) begin
            cmd_valid_reg <= 1'b0;
            cmd_read_reg <= 1'b0;
            cmd_addr_reg <= '0;
        end else begin
            cmd_valid_reg <= ~load_strobe_n;
            cmd_read_reg <= read_sel;
            cmd_addr_reg <= addr_in;
        end
    end

    // first write word on the true rise after the command
    always_ff @(posedge link_k) begin
        if (rst_k) begin
            wpend_reg <= 1'b0;
            waddr_reg <= '0;
            wd0_reg <= '0;
            wm0_reg <= '1;
        end else begin
            wpend_reg <= wr_go;
            if (wr_go) begin
                waddr_reg <= cmd_addr_reg;
                wd0_reg <= d_in;
                wm0_reg <= byte_lane_write_n;
            end
        end
    end

    // second write word on the complement rise of the same cycle
    always_ff @(negedge link_k) begin
        if (rst_k) begin
            wd1_neg_reg <= '0;
            wm1_neg_reg <= '1;
        end else if (wpend_reg) begin
            wd1_neg_reg <= d_in;
            wm1_neg_reg <= byte_lane_write_n;
        end
    end

    // completed write is parked; the parked one goes to the array
    always_ff @(posedge link_k) begin
        if (rst_k) begin
            hold_valid_reg <= 1'b0;
            hold_addr_reg <= '0;
            hold_data_reg <= '0;
            hold_lane_reg <= '1;
        end else if (wpend_reg) begin
            hold_valid_reg <= 1'b1;
            hold_addr_reg <= waddr_reg;
            hold_data_reg <= wbuf_data;
            hold_lane_reg <= wbuf_lane;
        end
    end

    assign core_bus.wr_en = wpend_reg & hold_valid_reg;
    assign core_bus.wr_addr = hold_addr_reg;
    assign core_bus.wr_data = hold_data_reg;
    assign core_bus.wr_lane_n = hold_lane_reg;

    // ---------------- link domain: read path with bypass ----------------
    wire [ADDR_W-1:0] raddr0 = cmd_addr_reg;
    wire [ADDR_W-1:0] raddr1 = burst_next(cmd_addr_reg);
    assign core_bus.rd_addr = raddr0;

    wire [WORD_W-1:0] arr0 = core_bus.rd_data[WORD_W-1:0];
    wire [WORD_W-1:0] arr1 = core_bus.rd_data[BW-1:WORD_W];
    wire [WORD_W-1:0] held0 = burst_pick(raddr0, hold_valid_reg, hold_addr_reg,
        hold_data_reg, hold_lane_reg, arr0);
    wire [WORD_W-1:0] held1 = burst_pick(raddr1, hold_valid_reg, hold_addr_reg,
        hold_data_reg, hold_lane_reg, arr1);
    wire [WORD_W-1:0] rword0 = burst_pick(raddr0, wpend_reg, waddr_reg,
        wbuf_data, wbuf_lane, held0);
    wire [WORD_W-1:0] rword1 = burst_pick(raddr1, wpend_reg, waddr_reg,
        wbuf_data, wbuf_lane, held1);

    logic rpend_reg;
    logic [WORD_W-1:0] r0_reg;
    logic [WORD_W-1:0] r1_reg;
    logic [WORD_W-1:0] q_pos_reg;
    logic oe_pos_reg;
    logic [WORD_W-1:0] q_neg_reg;
    logic oe_neg_reg;

    always_ff @(posedge link_k) begin
        if (rst_k) begin
            rpend_reg <= 1'b0;
            r0_reg <= '0;
            r1_reg <= '0;
        end else begin
            rpend_reg <= rd_go;
            if (rd_go) begin
                r0_reg <= rword0;
                r1_reg <= rword1;
            end
        end
    end

    // true-edge launch: word one without dll, word two with dll
    wire [WORD_W-1:0] q_pos_next = dll_on ? r1_reg : rword0;
    wire oe_pos_next = dll_on ? rpend_reg : rd_go;

    always_ff @(posedge link_k) begin
        if (rst_k) begin
            q_pos_reg <= '0;
            oe_pos_reg <= 1'b0;
        end else begin
            q_pos_reg <= q_pos_next;
            oe_pos_reg <= oe_pos_next;
        end
    end

    // complement-edge launch: word one with dll, word two without
    wire [WORD_W-1:0] q_neg_next = dll_on ? r0_reg : r1_reg;

    always_ff @(negedge link_k) begin
        if (rst_k) begin
            q_neg_reg <= '0;
            oe_neg_reg <= 1'b0;
        end else begin
            q_neg_reg <= q_neg_next;
            oe_neg_reg <= rpend_reg;
        end
    end

    // edge phase: high after a true rise, low after a complement rise
    logic ph_pos_reg;
    logic ph_neg_reg;

    always_ff @(posedge link_k) begin
        if (rst_k)
            ph_pos_reg <= 1'b0;
        else
            ph_pos_reg <= ~ph_pos_reg;
    end

    always_ff @(negedge link_k) begin
        if (rst_k)
            ph_neg_reg <= 1'b0;
        else
            ph_neg_reg <= ph_pos_reg;
    end

    wire phase_hi = ph_pos_reg ^ ph_neg_reg;

    // output launch shares the input clock pair
    assign q_out = phase_hi ? q_pos_reg : q_neg_reg;
    assign q_oe = phase_hi ? oe_pos_reg : oe_neg_reg;
    assign echo_clock_true = single_clk_reg ? ~phase_hi : phase_hi;
    assign echo_clock_comp = ~phase_hi;

    // ---------------- link domain: dll lock tracking ----------------
    dbs_pkg::dbs_dll_state_t dll_state_reg;
    dbs_pkg::dbs_dll_state_t dll_state_next;
    logic [dbs_pkg::DLL_LOCK_W-1:0] lock_cnt_reg;
    logic [dbs_pkg::DLL_LOCK_W-1:0] lock_cnt_next;

    localparam logic [dbs_pkg::DLL_LOCK_W-1:0] LOCK_LAST =
        dbs_pkg::DLL_LOCK_W'(dbs_pkg::DLL_LOCK_CYC - 1);

    always_comb begin
        dll_state_next = dll_state_reg;
        lock_cnt_next = '0;
        case (dll_state_reg)
            dbs_pkg::DBS_DLL_OFF: begin
                if (dll_on)
                    dll_state_next = dbs_pkg::DBS_DLL_LOCKING;
            end
            dbs_pkg::DBS_DLL_LOCKING: begin
                lock_cnt_next = lock_cnt_reg + 1'b1;
                if (!dll_on)
                    dll_state_next = dbs_pkg::DBS_DLL_OFF;
                else if (lock_cnt_reg == LOCK_LAST)
                    dll_state_next = dbs_pkg::DBS_DLL_LOCKED;
            end
            dbs_pkg::DBS_DLL_LOCKED: begin
                if (!dll_on)
                    dll_state_next = dbs_pkg::DBS_DLL_OFF;
            end
            default: dll_state_next = dbs_pkg::DBS_DLL_OFF;
        endcase
    end

    always_ff @(posedge link_k) begin
        if (rst_k || stop_k) begin
            dll_state_reg <= dbs_pkg::DBS_DLL_OFF;
            lock_cnt_reg <= '0;
        end else begin
            dll_state_reg <= dll_state_next;
            lock_cnt_reg <= lock_cnt_next;
        end
    end

    wire locked_k = (dll_state_reg == dbs_pkg::DBS_DLL_LOCKED);

    // gray activity count for clock-stop detection
    logic [dbs_pkg::GRAY_W-1:0] kgray_reg;

    always_ff @(posedge link_k) begin
        if (rst_k)
            kgray_reg <= dbs_pkg::GRAY_RST;
        else
            kgray_reg <= {kgray_reg[0], ~kgray_reg[1]};
    end

    // ---------------- system domain ----------------
    logic [dbs_pkg::GRAY_W-1:0] kg_s1_reg;
    logic [dbs_pkg::GRAY_W-1:0] kg_s2_reg;
    logic [dbs_pkg::GRAY_W-1:0] kg_s3_reg;
    logic [dbs_pkg::IDLE_W-1:0] idle_cnt_reg;
    logic [dbs_pkg::IDLE_W-1:0] idle_cnt_next;
    logic [dbs_pkg::SYNC_W-1:0] lock_sync_reg;
    logic stop_hold_reg;
    logic dll_locked_reg;
    logic [dbs_pkg::IMP_W-1:0] imp_cnt_reg;
    logic imp_update_reg;

    localparam logic [dbs_pkg::IDLE_W-1:0] STOP_CNT =
        dbs_pkg::IDLE_W'(dbs_pkg::CLK_STOP_CYC);
    localparam logic [dbs_pkg::IMP_W-1:0] IMP_LAST =
        dbs_pkg::IMP_W'(dbs_pkg::IMP_PERIOD_CYC - 1);

    wire k_moved = (kg_s2_reg != kg_s3_reg);
    wire idle_sat = (idle_cnt_reg >= STOP_CNT);

    always_comb begin
        if (k_moved)
            idle_cnt_next = '0;
        else if (idle_sat)
            idle_cnt_next = idle_cnt_reg;
        else
            idle_cnt_next = idle_cnt_reg + 1'b1;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            kg_s1_reg <= dbs_pkg::GRAY_RST;
            kg_s2_reg <= dbs_pkg::GRAY_RST;
            kg_s3_reg <= dbs_pkg::GRAY_RST;
            idle_cnt_reg <= '0;
            clk_stop_reg <= 1'b0;
        end else begin
            kg_s1_reg <= kgray_reg;
            kg_s2_reg <= kg_s1_reg;
            kg_s3_reg <= kg_s2_reg;
            idle_cnt_reg <= idle_cnt_next;
            clk_stop_reg <= (idle_cnt_next >= STOP_CNT);
        end
    end

    // stopped clock drops lock at once, until the link side has reset
    wire stop_hold_next = clk_stop_reg | (stop_hold_reg & lock_sync_reg[1]);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lock_sync_reg <= '0;
            stop_hold_reg <= 1'b0;
            dll_locked_reg <= 1'b0;
        end else begin
            lock_sync_reg <= {lock_sync_reg[0], locked_k};
            stop_hold_reg <= stop_hold_next;
            dll_locked_reg <= lock_sync_reg[1] & ~stop_hold_next;
        end
    end

    assign dll_locked = dll_locked_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            imp_cnt_reg <= '0;
            imp_update_reg <= 1'b0;
        end else begin
            imp_cnt_reg <= (imp_cnt_reg == IMP_LAST) ? '0 : imp_cnt_reg + 1'b1;
            imp_update_reg <= (imp_cnt_reg == IMP_LAST);
        end
    end

    assign imp_update = imp_update_reg;
endmodule

// *** hdl/dbs_pkg.sv ***
/*
 * shared constants and types for the two-word burst ddr sram port.
 * assumes a 50 MHz system clock and a link clock driven by the host.
 */
package dbs_pkg;
    localparam int WORD_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = 2;
    localparam int ADDR_W = 20;
    localparam int BURST = 2;
    // system clock period and clock-stop time in ns
    localparam int SYS_PERIOD_NS = 20;
    localparam int CLK_STOP_NS = 30;
    localparam int CLK_STOP_CYC = (CLK_STOP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int IDLE_W = 4;
    localparam int IMP_PERIOD_CYC = 1024;
    localparam int IMP_W = $clog2(IMP_PERIOD_CYC);
    localparam int DLL_LOCK_CYC = 1024;
    localparam int DLL_LOCK_W = $clog2(DLL_LOCK_CYC);
    localparam int SYNC_W = 2;
    localparam int GRAY_W = 2;
    localparam logic [GRAY_W-1:0] GRAY_RST = 2'h0;

    typedef enum logic [1:0] {
        DBS_DLL_OFF = 2'h0,
        DBS_DLL_LOCKING = 2'h1,
        DBS_DLL_LOCKED = 2'h3
    } dbs_dll_state_t;
endpackage

// *** hdl/dbs_core_if.sv ***
/*
 * port bundle between the link-side controller and the sram array.
 * assumes both ends run on the link clock.
 */
`timescale 1ns/100ps
interface dbs_core_if #(
    parameter int AW = dbs_pkg::ADDR_W,
    parameter int W = dbs_pkg::WORD_W,
    parameter int LN = dbs_pkg::LANES
);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [dbs_pkg::BURST*W-1:0] wr_data;
    logic [dbs_pkg::BURST*LN-1:0] wr_lane_n;
    logic [AW-1:0] rd_addr;
    logic [dbs_pkg::BURST*W-1:0] rd_data;

    modport ctrl (
        output wr_en,
        output wr_addr,
        output wr_data,
        output wr_lane_n,
        output rd_addr,
        input rd_data
    );
    modport mem (
        input wr_en,
        input wr_addr,
        input wr_data,
        input wr_lane_n,
        input rd_addr,
        output rd_data
    );
endinterface

// *** hdl/dbs_core.sv ***
/*
 * sram array: two-word burst write with per-lane enables, async two-word read.
 * assumes the controller has already resolved posted-write bypass.
 */
`timescale 1ns/100ps
module dbs_core #(
    parameter int AW = dbs_pkg::ADDR_W,
    parameter int W = dbs_pkg::WORD_W,
    parameter int LN = dbs_pkg::LANES
) (
    input wire logic clk,
    dbs_core_if.mem bus
);
    localparam int LW = W / LN;

    logic [W-1:0] mem_arr [0:(2**AW)-1];

    // second burst word sits at the address with its lsb flipped
    wire [AW-1:0] wr_addr_b = {bus.wr_addr[AW-1:1], ~bus.wr_addr[0]};
    wire [AW-1:0] rd_addr_b = {bus.rd_addr[AW-1:1], ~bus.rd_addr[0]};

    always_ff @(posedge clk) begin
        if (bus.wr_en) begin
            for (int l = 0; l < LN; l++) begin
                if (!bus.wr_lane_n[l])
                    mem_arr[bus.wr_addr][l*LW +: LW] <= bus.wr_data[l*LW +: LW];
                if (!bus.wr_lane_n[LN+l])
                    mem_arr[wr_addr_b][l*LW +: LW] <= bus.wr_data[W+l*LW +: LW];
            end
        end
    end

    assign bus.rd_data = {mem_arr[rd_addr_b], mem_arr[bus.rd_addr]};
endmodule

// *** sim/dbs_sram_port_checker.sv ***
/* pin assertions for the sram port, bound into it.
   assumes link inputs change only at link_k edges. */
`timescale 1ns/100ps
module dbs_sram_port_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic link_k,
    input wire logic load_strobe_n,
    input wire logic read_sel,
    input wire logic dll_disable_n,
    input wire logic q_oe,
    input wire logic echo_clock_comp,
    input wire logic dll_locked,
    input wire logic imp_update
);
    logic [10:0] gap_reg;
    logic seen_reg;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gap_reg <= 11'h0;
            seen_reg <= 1'b0;
        end else begin
            gap_reg <= imp_update ? 11'h0 : gap_reg + 11'h1;
            seen_reg <= seen_reg | imp_update;
        end
    end
    a_read_dll_on: assert property (@(posedge link_k) disable iff (rst)
        !load_strobe_n && read_sel && dll_disable_n |-> ##2 q_oe)
        else $error("read word late");
    a_read_dll_off: assert property (@(negedge link_k) disable iff (rst)
        !load_strobe_n && read_sel && !dll_disable_n |-> ##2 q_oe)
        else $error("short latency read late");
    a_bus_quiet: assert property (@(posedge link_k) disable iff (rst)
        (load_strobe_n || !read_sel) [*3] |-> !q_oe)
        else $error("bus driven without read");
    a_imp_period: assert property (@(posedge clk_sys) disable iff (rst)
        imp_update && seen_reg |-> gap_reg == 11'h3ff)
        else $error("impedance update period wrong");
    a_imp_missing: assert property (@(posedge clk_sys) disable iff (rst)
        seen_reg |-> gap_reg <= 11'h3ff)
        else $error("impedance update missing");
    a_imp_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        imp_update |=> !imp_update)
        else $error("impedance update too long");
    a_dll_off_idle: assert property (@(posedge clk_sys) disable iff (rst)
        !dll_disable_n && !$past(dll_disable_n, 8) |-> !dll_locked)
        else $error("lock with dll off");
    a_reset_clear: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(rst) |-> !dll_locked && !imp_update)
        else $error("outputs not cleared by reset");
    a_echo_comp: assert property (@(posedge link_k) disable iff (rst)
        echo_clock_comp)
        else $error("complement echo phase wrong");
endmodule

bind dbs_sram_port dbs_sram_port_checker u_chk (
    .clk_sys(clk_sys), .rst(rst), .link_k(link_k), .load_strobe_n(load_strobe_n),
    .read_sel(read_sel), .dll_disable_n(dll_disable_n), .q_oe(q_oe),
    .echo_clock_comp(echo_clock_comp), .dll_locked(dll_locked), .imp_update(imp_update)
);

// *** sim/dbs_host_model.sv ***
/* host controller model: link clock, burst commands, read word capture.
   assumes the port samples commands at link_k rises. */
`timescale 1ns/100ps
module dbs_host_model (
    output logic link_k,
    output logic out_clk_true,
    output logic out_clk_comp,
    output logic [dbs_pkg::ADDR_W-1:0] addr_in,
    output logic load_strobe_n,
    output logic read_sel,
    output logic [dbs_pkg::WORD_W-1:0] d_in,
    output logic [1:0] byte_lane_write_n,
    input wire logic [dbs_pkg::WORD_W-1:0] q_out,
    input wire logic q_oe
);
    logic run = 1'b1;
    logic strap = 1'b0;
    logic wr_a = 1'b0;
    logic wr_b = 1'b0;
    logic [17:0] w1_a, w2_a, w2_b;
    logic [1:0] l1_a, l2_a, l2_b;
    logic [17:0] got[$];
    assign #1 out_clk_true = strap | link_k;
    assign #1 out_clk_comp = strap | ~link_k;
    initial begin
        link_k = 1'b0;
        addr_in = 20'h0;
        load_strobe_n = 1'b1;
        read_sel = 1'b0;
        d_in = 18'h0;
        byte_lane_write_n = 2'h3;
        forever begin
            #6;
            if (run) link_k = ~link_k;
        end
    end
    always @(link_k) begin
        #3;
        if (q_oe === 1'b1) got.push_back(q_out);
    end
    task op(input logic ld_n, input logic rw, input logic [19:0] a, input logic [17:0] w1,
            input logic [17:0] w2, input logic [1:0] l1, input logic [1:0] l2);
        @(posedge link_k);
        load_strobe_n <= ld_n;
        read_sel <= rw;
        addr_in <= a;
        d_in <= wr_b ? w2_b : ~d_in;
        byte_lane_write_n <= wr_b ? l2_b : 2'h3;
        @(negedge link_k);
        d_in <= wr_a ? w1_a : ~d_in;
        byte_lane_write_n <= wr_a ? l1_a : 2'h3;
        wr_b = wr_a;
        w2_b = w2_a;
        l2_b = l2_a;
        wr_a = !ld_n && !rw;
        w1_a = w1;
        w2_a = w2;
        l1_a = l1;
        l2_a = l2;
    endtask
    task wr(input logic [19:0] a, input logic [17:0] w1, input logic [17:0] w2,
            input logic [1:0] l1, input logic [1:0] l2);
        op(1'b0, 1'b0, a, w1, w2, l1, l2);
    endtask
    task rd(input logic [19:0] a);
        op(1'b0, 1'b1, a, 18'h0, 18'h0, 2'h3, 2'h3);
    endtask
    task nop;
        op(1'b1, ~read_sel, ~addr_in, 18'h0, 18'h0, 2'h3, 2'h3);
    endtask
endmodule

// *** sim/dbs_sram_port_tb.sv ***
/* self-checking bench for the sram port driven by the host model.
   assumes the host model drives every link-side input except dll_disable_n, which the bench drives. */
`timescale 1ns/100ps
module dbs_sram_port_tb;
    logic clk_sys;
    logic rst = 1'b1;
    logic dll_disable_n = 1'b1;
    logic link_k, out_clk_true, out_clk_comp, load_strobe_n, read_sel;
    logic [dbs_pkg::ADDR_W-1:0] addr_in;
    logic [dbs_pkg::WORD_W-1:0] d_in, q_out;
    logic [1:0] byte_lane_write_n;
    logic q_oe, echo_clock_true, echo_clock_comp, dll_locked, imp_update;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    dbs_host_model host (.link_k(link_k), .out_clk_true(out_clk_true),
        .out_clk_comp(out_clk_comp), .addr_in(addr_in), .load_strobe_n(load_strobe_n),
        .read_sel(read_sel), .d_in(d_in), .byte_lane_write_n(byte_lane_write_n),
        .q_out(q_out), .q_oe(q_oe));
    dbs_sram_port uut (.clk_sys(clk_sys), .rst(rst), .link_k(link_k), .addr_in(addr_in),
        .load_strobe_n(load_strobe_n), .read_sel(read_sel), .d_in(d_in),
        .byte_lane_write_n(byte_lane_write_n), .out_clk_true(out_clk_true),
        .out_clk_comp(out_clk_comp), .dll_disable_n(dll_disable_n), .q_out(q_out),
        .q_oe(q_oe), .echo_clock_true(echo_clock_true), .echo_clock_comp(echo_clock_comp),
        .dll_locked(dll_locked), .imp_update(imp_update));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            mismatches = mismatches + 1;
            wrap_up;
        end
    end
    task wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task check_word(input logic [17:0] got, input logic [17:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task check_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task expect_word(input logic [17:0] exp);
        logic [17:0] w;
        w = 18'hx;
        if (host.got.size() > 0) w = host.got.pop_front();
        check_word(w, exp);
    endtask
    task do_reset(input logic strap, input logic dll_on);
        @(posedge clk_sys);
        rst <= 1'b1;
        dll_disable_n <= dll_on;
        host.strap <= strap;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge link_k);
        host.got.delete();
    endtask
    task check_echo(input logic exp_true);
        @(posedge link_k);
        #3;
        check_bit(echo_clock_true, exp_true);
        check_bit(echo_clock_comp, 1'b0);
    endtask
    task t_dll;
        repeat (990) @(posedge link_k);
        #1 check_bit(dll_locked, 1'b0);
        repeat (70) @(posedge link_k);
        #1 check_bit(dll_locked, 1'b1);
        @(negedge link_k);
        host.run = 1'b0;
        #200 check_bit(dll_locked, 1'b0);
        host.run = 1'b1;
        repeat (990) @(posedge link_k);
        #1 check_bit(dll_locked, 1'b0);
        repeat (70) @(posedge link_k);
        #1 check_bit(dll_locked, 1'b1);
    endtask
    task t_bypass;
        host.wr(20'h10, 18'h1a1, 18'h1a2, 2'h0, 2'h0);
        host.rd(20'h10);
        host.nop;
        host.wr(20'h21, 18'h2b1, 18'h2b2, 2'h0, 2'h0);
        host.rd(20'h20);
        host.rd(20'h11);
        repeat (3) host.nop;
        expect_word(18'h1a1);
        expect_word(18'h1a2);
        expect_word(18'h2b2);
        expect_word(18'h2b1);
        expect_word(18'h1a2);
        expect_word(18'h1a1);
    endtask
    task t_lanes;
        host.wr(20'h30, {9'h0a1, 9'h0b2}, {9'h0c3, 9'h0d4}, 2'h0, 2'h0);
        host.wr(20'h30, {9'h1cc, 9'h133}, 18'h3ffff, 2'h2, 2'h3);
        host.wr(20'h31, {9'h1ee, 9'h1ff}, 18'h0, 2'h1, 2'h3);
        host.rd(20'h30);
        repeat (3) host.nop;
        expect_word({9'h0a1, 9'h133});
        expect_word({9'h1ee, 9'h0d4});
        host.op(1'b1, 1'b1, 20'h30, 18'h0, 18'h0, 2'h0, 2'h0);
        repeat (3) host.nop;
        check_bit(host.got.size() == 0, 1'b1);
    endtask
    task t_imp;
        int n;
        n = 0;
        while (imp_update !== 1'b1 && n < 1100) begin
            @(posedge clk_sys);
            #1 n++;
        end
        n = 0;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while (imp_update !== 1'b1 && n < 1100);
        check_bit(n == 1024, 1'b1);
    endtask
    task t_single;
        check_echo(1'b0);
        host.wr(20'h40, 18'h111, 18'h222, 2'h0, 2'h0);
        host.rd(20'h40);
        repeat (3) host.nop;
        expect_word(18'h111);
        expect_word(18'h222);
        check_bit(dll_locked, 1'b0);
    endtask
    initial begin
        do_reset(1'b0, 1'b1);
        check_bit(q_oe, 1'b0);
        check_bit(dll_locked, 1'b0);
        t_dll;
        t_bypass;
        t_lanes;
        check_echo(1'b1);
        t_imp;
        do_reset(1'b1, 1'b0);
        t_single;
        wrap_up;
    end
endmodule
